// file: logic/spm_pin_cell.sv
// function selector of one port pin
`timescale 1ns/1ps
module spm_pin_cell (
    input wire logic i_latch,    // output latch bit
    input wire logic i_dir,      // direction bit, 1 = input
    input wire logic i_ana_en,   // analog channel select bit
    input wire logic i_seg_en,   // segment enable bit
    input wire logic i_ovr_en,   // reference or charger output enable
    input wire logic i_pin_sync, // synchronised pin level
    output logic o_out,          // digital drive value
    output logic o_oe,           // digital drive enable
    output logic o_rd,           // value seen in pin level register
    output logic o_seg,          // pad routed to segment drive
    output logic o_ovr,          // pad routed to reference or charger
    output logic o_ana           // pad routed to analog channel
);
    logic dig_ok;

    always_comb begin
        o_seg = i_seg_en;
        o_ovr = !i_seg_en && i_ovr_en;
        o_ana = !i_seg_en && !i_ovr_en && i_ana_en;
        // override functions take the pad whatever the direction bit says
        dig_ok = !i_seg_en && !i_ovr_en;
        o_oe = dig_ok && !i_dir;
        o_out = dig_ok && !i_dir && i_latch;
        o_rd = dig_ok && !i_ana_en && i_pin_sync;
    end
endmodule

// file: logic/spm_pkg.sv
// package of register map, field positions and reset values for the seven-bit port
// ==========================================================================
// ==========================================================================
package spm_pkg;

    // ==================================================================
    // register addresses
    localparam logic [7:0] ADDR_PIN_LEVEL = 8'h00;
    localparam logic [7:0] ADDR_OUT_LATCH = 8'h01;
    localparam logic [7:0] ADDR_DIRECTION = 8'h02;
    localparam logic [7:0] ADDR_ANA_LOW = 8'h03;
    localparam logic [7:0] ADDR_ANA_HIGH = 8'h04;
    localparam logic [7:0] ADDR_CMP_STATUS = 8'h05;
    localparam logic [7:0] ADDR_VREF_CTRL = 8'h06;
    localparam logic [7:0] ADDR_SEG_MID = 8'h07;
    localparam logic [7:0] ADDR_SEG_HIGH = 8'h08;

    // ==================================================================
    // reset values
    localparam logic [7:0] RST_OUT_LATCH = 8'h00;
    localparam logic [7:0] RST_DIRECTION = 8'hfe;
    localparam logic [7:0] RST_ANA_LOW = 8'hff;
    localparam logic [7:0] RST_ANA_HIGH = 8'hff;
    localparam logic [7:0] RST_VREF_CTRL = 8'h00;
    localparam logic [7:0] RST_SEG_MID = 8'h00;
    localparam logic [7:0] RST_SEG_HIGH = 8'h00;

    // ==================================================================
    // field positions and masks
    localparam logic [7:0] PORT_IMPL_MASK = 8'hfe;
    localparam logic [7:0] CMP_STATUS_MASK = 8'he0;
    localparam int CMP_OUT_LSB = 5;
    localparam int VREF_EN_BIT = 7;
    localparam int VREF_OE_BIT = 6;
    // analog channel per pin: pins 1,2 on low 6,7; pins 3..6 on high 0..3; pin 7 on low 5
    localparam int ANA_PIN1_BIT = 6;
    localparam int ANA_PIN2_BIT = 7;
    localparam int ANA_PIN3_BIT = 0;
    localparam int ANA_PIN7_BIT = 5;
    // segment per pin: pins 1..5 on mid 3..7; pins 6,7 on high 0,1
    localparam int SEG_PIN1_BIT = 3;
    localparam int SEG_PIN6_BIT = 0;
    localparam int REF_PIN = 5;
    localparam int CHARGER_PIN = 3;
    localparam int SLAVE_SEL_PIN = 7;

endpackage

// file: logic/spm_port_top.sv
// seven-bit general-purpose port with pin multiplexing and register set
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
module spm_port_top
    import spm_pkg::*;
(
    input wire logic i_clk,                // system clock, 100 MHz
    input wire logic i_arst_n,             // power-on reset, active low
    input wire logic [7:0] i_addr,         // register address
    input wire logic [7:0] i_wdata,        // write data
    input wire logic i_wr,                 // write strobe
    input wire logic i_rd,                 // read strobe
    output logic [7:0] o_rdata,            // read data, cycle after strobe
    input wire logic [7:1] i_pin_in,       // pad input levels
    output logic [7:1] o_pin_out,          // pad digital drive value
    output logic [7:1] o_pin_oe,           // pad digital drive enable
    output logic [7:1] o_seg_route,        // pad connected to its segment drive
    output logic [7:1] o_ana_route,        // pad connected to its analog channel
    output logic o_ref_route,              // pin five carries reference output
    output logic o_charger_route,          // pin three carries charger output
    input wire logic [2:0] i_cmp_out,      // comparator outputs
    input wire logic i_charger_en,         // pulse charger output request
    output logic o_ref_enable,             // reference generator enabled
    output logic [5:0] o_ref_setting,      // reference range, source and level
    output logic o_serial_slave_select_in  // slave select to serial module
);

    // ==================================================================
    // registers
    logic [7:0] output_latch_reg_q;
    logic [7:0] direction_reg_q;
    logic [7:0] analog_select_low_q;
    logic [7:0] analog_select_high_q;
    logic [7:0] voltage_ref_control_q;
    logic [7:0] segment_enable_mid_q;
    logic [7:0] segment_enable_high_q;

    // ==================================================================
    // per-pin control vectors
    logic [7:1] pin_sync;
    logic [7:1] ana_en;
    logic [7:1] seg_en;
    logic [7:1] ovr_en;
    logic [7:1] pad_out_d;
    logic [7:1] pad_oe_d;
    logic [7:1] pad_rd;
    logic [7:1] pad_seg_d;
    logic [7:1] pad_ovr_d;
    logic [7:1] pad_ana_d;
    logic ref_out_en;
    logic [7:0] pin_level_reg;
    logic [7:0] rdata_d;

    spm_sync #(
        .WIDTH(7)
    ) u_sync (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_async(i_pin_in),
        .o_sync(pin_sync)
    );

    assign ref_out_en = voltage_ref_control_q[VREF_EN_BIT]
        && voltage_ref_control_q[VREF_OE_BIT];

    always_comb begin
        ana_en[1] = analog_select_low_q[ANA_PIN1_BIT];
        ana_en[2] = analog_select_low_q[ANA_PIN2_BIT];
        ana_en[6:3] = analog_select_high_q[ANA_PIN3_BIT +: 4];
        ana_en[7] = analog_select_low_q[ANA_PIN7_BIT];
        seg_en[5:1] = segment_enable_mid_q[SEG_PIN1_BIT +: 5];
        seg_en[7:6] = segment_enable_high_q[SEG_PIN6_BIT +: 2];
        ovr_en = '0;
        ovr_en[REF_PIN] = ref_out_en;
        ovr_en[CHARGER_PIN] = i_charger_en;
    end

    // ==================================================================
    // pin cells
    for (genvar p = 1; p <= 7; p++) begin : g_pin
        spm_pin_cell u_cell (
            .i_latch(output_latch_reg_q[p]),
            .i_dir(direction_reg_q[p]),
            .i_ana_en(ana_en[p]),
            .i_seg_en(seg_en[p]),
            .i_ovr_en(ovr_en[p]),
            .i_pin_sync(pin_sync[p]),
            .o_out(pad_out_d[p]),
            .o_oe(pad_oe_d[p]),
            .o_rd(pad_rd[p]),
            .o_seg(pad_seg_d[p]),
            .o_ovr(pad_ovr_d[p]),
            .o_ana(pad_ana_d[p])
        );
    end

    assign pin_level_reg = {pad_rd, 1'b0};

    // ==================================================================
    // register writes
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            output_latch_reg_q <= RST_OUT_LATCH;
        end else if (i_wr && (i_addr == ADDR_OUT_LATCH || i_addr == ADDR_PIN_LEVEL)) begin
            // writing the pin level register lands in the latch
            output_latch_reg_q <= i_wdata & PORT_IMPL_MASK;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            direction_reg_q <= RST_DIRECTION;
        end else if (i_wr && i_addr == ADDR_DIRECTION) begin
            direction_reg_q <= i_wdata & PORT_IMPL_MASK;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            analog_select_low_q <= RST_ANA_LOW;
            analog_select_high_q <= RST_ANA_HIGH;
        end else if (i_wr) begin
            if (i_addr == ADDR_ANA_LOW) begin
                analog_select_low_q <= i_wdata;
            end
            if (i_addr == ADDR_ANA_HIGH) begin
                analog_select_high_q <= i_wdata;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            voltage_ref_control_q <= RST_VREF_CTRL;
        end else if (i_wr && i_addr == ADDR_VREF_CTRL) begin
            voltage_ref_control_q <= i_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            segment_enable_mid_q <= RST_SEG_MID;
            segment_enable_high_q <= RST_SEG_HIGH;
        end else if (i_wr) begin
            if (i_addr == ADDR_SEG_MID) begin
                segment_enable_mid_q <= i_wdata;
            end
            if (i_addr == ADDR_SEG_HIGH) begin
                segment_enable_high_q <= i_wdata;
            end
        end
    end

    // ==================================================================
    // register reads
    always_comb begin
        unique case (i_addr)
            ADDR_PIN_LEVEL: rdata_d = pin_level_reg;
            ADDR_OUT_LATCH: rdata_d = output_latch_reg_q;
            ADDR_DIRECTION: rdata_d = direction_reg_q;
            ADDR_ANA_LOW: rdata_d = analog_select_low_q;
            ADDR_ANA_HIGH: rdata_d = analog_select_high_q;
            ADDR_CMP_STATUS: rdata_d = {i_cmp_out, 5'h00} & CMP_STATUS_MASK;
            ADDR_VREF_CTRL: rdata_d = voltage_ref_control_q;
            ADDR_SEG_MID: rdata_d = segment_enable_mid_q;
            ADDR_SEG_HIGH: rdata_d = segment_enable_high_q;
            default: rdata_d = 8'h00;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= rdata_d;
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // ==================================================================
    // registered pad controls
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pin_out <= '0;
            o_pin_oe <= '0;
            o_seg_route <= '0;
            o_ana_route <= '1;
            o_ref_route <= 1'b0;
            o_charger_route <= 1'b0;
        end else begin
            o_pin_out <= pad_out_d;
            o_pin_oe <= pad_oe_d;
            o_seg_route <= pad_seg_d;
            o_ana_route <= pad_ana_d;
            o_ref_route <= pad_ovr_d[REF_PIN];
            o_charger_route <= pad_ovr_d[CHARGER_PIN];
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_ref_enable <= 1'b0;
            o_ref_setting <= 6'h00;
        end else begin
            o_ref_enable <= voltage_ref_control_q[VREF_EN_BIT];
            o_ref_setting <= voltage_ref_control_q[5:0];
        end
    end

    // slave select idles high unless pin seven is an input without segment
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_serial_slave_select_in <= 1'b1;
        end else if (direction_reg_q[SLAVE_SEL_PIN] && !seg_en[SLAVE_SEL_PIN]) begin
            o_serial_slave_select_in <= pin_sync[SLAVE_SEL_PIN];
        end else begin
            o_serial_slave_select_in <= 1'b1;
        end
    end

endmodule

// file: logic/spm_sync.sv
// two-flop synchroniser for pin levels
`timescale 1ns/1ps
module spm_sync #(
    parameter int WIDTH = 7
) (
    input wire logic i_clk,               // system clock
    input wire logic i_arst_n,            // async reset, active low
    input wire logic [WIDTH-1:0] i_async, // level from outside the clock domain
    output logic [WIDTH-1:0] o_sync       // synchronised level
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_q <= '0;
            o_sync <= '0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule

// file: verif/spm_pad_model.sv
// pad model: outside circuit that follows a driven pad, else forces its own level
`timescale 1ns/1ps
module spm_pad_model (
    input wire logic [7:1] i_drive,    // pad drive value
    input wire logic [7:1] i_drive_en, // pad drive enable
    input wire logic [7:1] i_ext,      // level forced from outside
    output logic [7:1] o_level         // resulting pad level
);
    // ==========================================================
    // pad resolution
    assign o_level = (i_drive & i_drive_en) | (i_ext & ~i_drive_en);
endmodule

// file: verif/spm_port_asserts.sv
// checker of pin routing and read rules of the seven-bit port
`timescale 1ns/1ps
module spm_port_asserts
    import spm_pkg::*;
(
    input wire logic i_clk,                   // clock
    input wire logic i_arst_n,                // reset
    input wire logic [7:0] i_addr,            // address
    input wire logic i_rd,                    // read strobe
    input wire logic [7:0] o_rdata,           // read data
    input wire logic [7:1] o_pin_out,         // drive value
    input wire logic [7:1] o_pin_oe,          // drive enable
    input wire logic [7:1] o_seg_route,       // segment route
    input wire logic [7:1] o_ana_route,       // analog route
    input wire logic o_ref_route,             // reference route
    input wire logic o_charger_route,         // charger route
    input wire logic o_serial_slave_select_in // slave select
);
    // ==========================================================
    // assertions
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    a_seg_owns_pin: assert property (
        (o_seg_route & (o_pin_oe | o_ana_route)) == 7'h00) else $error("segment pad shared");
    a_out_when_driven: assert property (
        (o_pin_out & ~o_pin_oe) == 7'h00) else $error("drive value on undriven pad");
    a_ref_blocks_io: assert property (
        o_ref_route |-> !o_pin_oe[5] && !o_ana_route[5]) else $error("pin five not freed");
    a_charger_no_oe: assert property (
        o_charger_route |-> !o_pin_oe[3] && !o_ana_route[3]) else $error("pin three driven");
    a_bit_zero_read: assert property (
        i_rd && i_addr <= ADDR_DIRECTION |=> !o_rdata[0]) else $error("bit zero set");
    a_ss_seg_forced: assert property (
        o_seg_route[7] |-> o_serial_slave_select_in) else $error("slave select not forced");
    a_reset_analog: assert property (
        $rose(i_arst_n) |-> o_ana_route == 7'h7f && o_pin_oe == 7'h00) else $error("reset routes");
    a_seg_over_ref: assert property (
        o_seg_route[5] |-> !o_ref_route) else $error("reference over segment");
    c_seg_all: cover property (o_seg_route == 7'h7f);
    c_ref: cover property (o_ref_route);
    c_charger: cover property (o_charger_route);
endmodule

bind spm_port_top spm_port_asserts spm_port_asserts_i (.i_clk, .i_arst_n, .i_addr, .i_rd,
    .o_rdata, .o_pin_out, .o_pin_oe, .o_seg_route, .o_ana_route, .o_ref_route,
    .o_charger_route, .o_serial_slave_select_in);

// file: verif/spm_port_top_tb.sv
// self-checking bench of the seven-bit port
`timescale 1ns/1ps
module spm_port_top_tb;
    import spm_pkg::*;
    logic i_clk, i_arst_n, i_wr, i_rd, i_charger_en, o_ref_route, o_charger_route;
    logic o_ref_enable, o_serial_slave_select_in;
    logic [7:0] i_addr, i_wdata, o_rdata, rv, lat, dir;
    logic [7:1] i_pin_in, o_pin_out, o_pin_oe, o_seg_route, o_ana_route, ext;
    logic [2:0] i_cmp_out;
    logic [5:0] o_ref_setting;
    logic [31:0] seed;
    logic [7:0] rst_tab [10] = '{8'h00, 8'h00, 8'hfe, 8'hff, 8'hff, 8'ha0, 8'h00, 8'h00,
        8'h00, 8'h00};
    int n_errors;
    int checks;

    spm_port_top spm_port_top_i (.i_clk, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
        .o_rdata, .i_pin_in, .o_pin_out, .o_pin_oe, .o_seg_route, .o_ana_route, .o_ref_route,
        .o_charger_route, .i_cmp_out, .i_charger_en, .o_ref_enable, .o_ref_setting,
        .o_serial_slave_select_in);
    spm_pad_model spm_pad_model_i (.i_drive(o_pin_out), .i_drive_en(o_pin_oe), .i_ext(ext),
        .o_level(i_pin_in));

    // ==========================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // pin level read with all pins digital
    function automatic logic [7:0] exp_rd(input logic [7:0] l, d, input logic [7:1] e);
        return {(d[7:1] & e) | (~d[7:1] & l[7:1]), 1'b0};
    endfunction
    task cmp(input logic [7:0] got, exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, d);
        @(posedge i_clk);
        i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge i_clk);
        i_addr <= a; i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 rv = o_rdata;
    endtask
    task settle(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task report_and_stop;
        $display("errors=%0d checks=%0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ==========================================================
    // clock, watchdog, sequence
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    initial begin
        repeat (5000) @(posedge i_clk);
        n_errors++;
        report_and_stop;
    end
    initial begin
        seed = 32'd51590; n_errors = 0; checks = 0; ext = 7'h55;
        i_arst_n = 1'b0; i_wr = 1'b0; i_rd = 1'b0; i_addr = 8'h00; i_wdata = 8'h00;
        i_charger_en = 1'b0; i_cmp_out = 3'h5;
        repeat (10) @(posedge i_clk);
        i_arst_n <= 1'b1;
        settle(1);
        cmp({o_ana_route, 1'b0}, 8'hfe);
        wr(ADDR_CMP_STATUS, 8'h1f);
        wr(8'h09, 8'hff);
        for (int k = 0; k < 10; k++) begin
            rd(k[7:0]); cmp(rv, rst_tab[k]);
        end
        wr(ADDR_ANA_LOW, 8'h00);
        wr(ADDR_ANA_HIGH, 8'h00);
        for (int k = 0; k < 24; k++) begin
            seed = xs(seed);
            lat = (k == 0) ? 8'hff : seed[7:0];
            dir = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : seed[15:8];
            ext <= seed[22:16];
            i_cmp_out <= seed[26:24];
            wr(ADDR_OUT_LATCH, lat);
            wr(ADDR_DIRECTION, dir);
            // a pad that changes direction needs the synchroniser and slave select flop
            settle(4);
            cmp({o_pin_oe, 1'b0}, {~dir[7:1], 1'b0});
            cmp({o_pin_out, 1'b0}, {lat[7:1] & ~dir[7:1], 1'b0});
            cmp({7'h0, o_serial_slave_select_in}, {7'h0, dir[7] ? ext[7] : 1'b1});
            rd(ADDR_PIN_LEVEL); cmp(rv, exp_rd(lat, dir, ext));
            rd(ADDR_DIRECTION); cmp(rv, dir & 8'hfe);
            rd(ADDR_CMP_STATUS); cmp(rv, {seed[26:24], 5'h00});
        end
        wr(ADDR_ANA_LOW, 8'hff);
        wr(ADDR_ANA_HIGH, 8'hff);
        settle(1);
        cmp({o_ana_route, 1'b0}, 8'hfe);
        cmp({o_pin_out, 1'b0}, {lat[7:1] & ~dir[7:1], 1'b0});
        rd(ADDR_PIN_LEVEL); cmp(rv, 8'h00);
        wr(ADDR_ANA_LOW, 8'h00);
        wr(ADDR_ANA_HIGH, 8'h00);
        ext <= 7'h00;
        wr(ADDR_DIRECTION, 8'h80);
        wr(ADDR_SEG_MID, 8'hf8);
        wr(ADDR_SEG_HIGH, 8'h03);
        settle(4);
        cmp({o_seg_route, o_serial_slave_select_in}, 8'hff);
        cmp({o_pin_oe, 1'b0}, 8'h00);
        rd(ADDR_PIN_LEVEL); cmp(rv, 8'h00);
        wr(ADDR_SEG_MID, 8'h00);
        wr(ADDR_SEG_HIGH, 8'h00);
        wr(ADDR_DIRECTION, 8'h00);
        wr(ADDR_PIN_LEVEL, 8'hff); // lands in the output latch
        wr(ADDR_VREF_CTRL, 8'hd5);
        settle(3);
        cmp({o_ref_route, o_ref_enable, o_ref_setting}, 8'hd5);
        cmp({o_pin_oe, 1'b0}, 8'hde);
        rd(ADDR_PIN_LEVEL); cmp(rv, 8'hde);
        wr(ADDR_SEG_MID, 8'h80);
        settle(1);
        cmp({o_ref_route, o_seg_route}, 8'h10);
        wr(ADDR_SEG_MID, 8'h00);
        wr(ADDR_VREF_CTRL, 8'h40);
        @(posedge i_clk);
        i_charger_en <= 1'b1;
        settle(2);
        cmp({6'h00, o_ref_route, o_charger_route}, 8'h01);
        cmp({1'b0, o_pin_oe}, 8'h7b);
        @(posedge i_clk);
        i_charger_en <= 1'b0;
        settle(2);
        cmp({1'b0, o_pin_oe}, 8'h7f);
        report_and_stop;
    end
endmodule
